// file: pkg/dsac_pkg.sv
package dsac_pkg;
   // register map, fieldbus parameter port (word index as printed)
   localparam logic [11:0] CHANNEL_LOCK_OFFSET = 12'h13c;
   localparam logic [11:0] OP_STATE_OFFSET = 12'h140;
   localparam logic [15:0] CHANNEL_LOCK_RESET = 16'h0000;
   localparam int LOCK_BIT_POS = 0;
   localparam logic [15:0] LOCK_RELEASE_VAL = 16'h0000;
   localparam logic [15:0] LOCK_FIELDBUS_VAL = 16'h0001;

   // operating modes
   localparam logic [2:0] MODE_JOG = 3'h1;
   localparam logic [2:0] MODE_SPEED = 3'h2;
   localparam logic [2:0] MODE_PROF_POS = 3'h3;
   localparam logic [2:0] MODE_PROF_VEL = 3'h4;
   localparam logic [2:0] MODE_HOMING = 3'h5;

   // error classes
   localparam logic [2:0] ECLASS_WARN = 3'h0;
   localparam logic [2:0] ECLASS_QSTOP = 3'h1;
   localparam logic [2:0] ECLASS_QSTOP_OFF = 3'h2;
   localparam logic [2:0] ECLASS_FATAL = 3'h3;
   localparam logic [2:0] ECLASS_UNCTRL = 3'h4;

   // state numbers as read by the fieldbus
   localparam logic [3:0] ST_NUM_START = 4'h1;
   localparam logic [3:0] ST_NUM_FAULT = 4'h9;

   typedef struct packed {
      logic enable_req;
      logic disable_req;
      logic fault_reset;
   } dsac_cmd_t;

   typedef struct packed {
      logic position_loop;
      logic velocity_loop;
      logic profile_gen_on;
   } dsac_loop_t;

   typedef struct packed {
      logic valid;
      logic [2:0] eclass;
   } dsac_err_t;
endpackage

// file: hdl/dsac_mode_map.sv
`timescale 1ns/1ps
module dsac_mode_map
   import dsac_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   input wire logic [2:0] mode_sel,
   input wire logic mode_run,
   output dsac_pkg::dsac_loop_t loop_sel
);
   wire is_speed = (mode_sel == MODE_SPEED);
   wire is_pos = (mode_sel == MODE_JOG) || (mode_sel == MODE_PROF_POS) ||
      (mode_sel == MODE_PROF_VEL) || (mode_sel == MODE_HOMING);
   dsac_loop_t loop_next;
   assign loop_next.velocity_loop = mode_run && is_speed;
   assign loop_next.position_loop = mode_run && is_pos;
   assign loop_next.profile_gen_on = mode_run && is_pos && !is_speed;

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         loop_sel <= '0;
      end else if (clk_en) begin
         loop_sel <= loop_next;
      end
   end

   a_speed_no_profile: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && mode_run && is_speed |=> loop_sel.velocity_loop && !loop_sel.profile_gen_on)
      else $error("speed mode used profile generator");
   a_pos_with_profile: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && mode_run && is_pos |=> loop_sel.position_loop && loop_sel.profile_gen_on)
      else $error("position mode without profile generator");
endmodule

// file: hdl/dsac_arbiter.sv
`timescale 1ns/1ps
module dsac_arbiter
   import dsac_pkg::*;
(
   input wire logic lock_fieldbus,
   input wire logic tool_exclusive,
   input wire dsac_pkg::dsac_cmd_t fb_cmd,
   input wire dsac_pkg::dsac_cmd_t tool_cmd,
   input wire dsac_pkg::dsac_cmd_t io_cmd,
   output dsac_pkg::dsac_cmd_t cmd_out,
   output logic fb_refused,
   output logic tool_refused,
   output logic io_refused
);
   // the tool claim outranks the fieldbus lock so a commissioning session
   // cannot be stolen by a parameter write
   wire fb_ok = !tool_exclusive;
   wire tool_ok = !lock_fieldbus || tool_exclusive;
   wire io_ok = !lock_fieldbus && !tool_exclusive;
   assign cmd_out = (fb_ok ? fb_cmd : '0) | (tool_ok ? tool_cmd : '0) |
      (io_ok ? io_cmd : '0);
   assign fb_refused = !fb_ok && (fb_cmd != '0);
   assign tool_refused = !tool_ok && (tool_cmd != '0);
   assign io_refused = !io_ok && (io_cmd != '0);
endmodule

// file: hdl/dsac_supervisor.sv
`timescale 1ns/1ps
module dsac_supervisor
   import dsac_pkg::*;
(
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire logic clk_en,
   // fieldbus parameter port
   input wire logic par_wr,
   input wire logic par_rd,
   input wire logic [11:0] par_addr,
   input wire logic [15:0] par_wdata,
   output logic [15:0] par_rdata,
   // command channels
   input wire dsac_pkg::dsac_cmd_t fb_cmd,
   input wire dsac_pkg::dsac_cmd_t tool_cmd,
   input wire dsac_pkg::dsac_cmd_t io_cmd,
   input wire logic tool_exclusive,
   // non-lockable inputs
   input wire logic halt_in,
   input wire logic pos_limit_switch,
   input wire logic neg_limit_switch,
   input wire logic home_switch,
   input wire logic safe_torque_off_a,
   input wire logic safe_torque_off_b,
   // internal status
   input wire logic init_done,
   input wire logic param_done,
   input wire logic power_ok,
   input wire dsac_pkg::dsac_err_t err_in,
   input wire logic standstill,
   input wire logic [2:0] mode_sel,
   // power stage and motion side
   output logic power_enable,
   output logic quick_stop,
   output logic motion_halt,
   output logic limit_pos_stop,
   output logic limit_neg_stop,
   output logic home_seen,
   output logic mode_run,
   output logic warning,
   output dsac_pkg::dsac_loop_t loop_sel,
   output logic [3:0] op_state,
   output logic cmd_refused
);
   typedef enum logic [8:0] {
      S_START = 9'h001,
      S_NOT_READY = 9'h002,
      S_DISABLED = 9'h004,
      S_READY = 9'h008,
      S_ON = 9'h010,
      S_OP = 9'h020,
      S_QSTOP = 9'h040,
      S_REACT = 9'h080,
      S_FAULT = 9'h100
   } dsac_state_t;

   dsac_state_t state_reg, state_next;
   logic [15:0] channel_lock_reg;
   logic [2:0] eclass_reg, eclass_next;
   logic unclearable_reg;
   dsac_cmd_t cmd;
   logic fb_ref, tool_ref, io_ref, enable_refused;

   ////////////////////////////////////////////////////////////////////////
   // fieldbus parameter port
   wire lock_wr = par_wr && (par_addr == CHANNEL_LOCK_OFFSET);
   wire lock_fieldbus = channel_lock_reg[LOCK_BIT_POS];
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         channel_lock_reg <= CHANNEL_LOCK_RESET;
      end else if (clk_en && lock_wr) begin
         channel_lock_reg <= par_wdata;
      end
   end
   wire [15:0] rd_mux = (par_addr == CHANNEL_LOCK_OFFSET) ? channel_lock_reg :
      (par_addr == OP_STATE_OFFSET) ? {12'h000, op_state} : 16'h0000;
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         par_rdata <= 16'h0000;
      end else if (clk_en && par_rd) begin
         par_rdata <= rd_mux;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channel arbitration and mode map
   dsac_arbiter u_arb (
      .lock_fieldbus(lock_fieldbus),
      .tool_exclusive(tool_exclusive),
      .fb_cmd(fb_cmd),
      .tool_cmd(tool_cmd),
      .io_cmd(io_cmd),
      .cmd_out(cmd),
      .fb_refused(fb_ref),
      .tool_refused(tool_ref),
      .io_refused(io_ref)
   );

   dsac_mode_map u_map (
      .ref_clk(ref_clk),
      .arst_n(arst_n),
      .clk_en(clk_en),
      .mode_sel(mode_sel),
      .mode_run(mode_run),
      .loop_sel(loop_sel)
   );

   ////////////////////////////////////////////////////////////////////////
   // state machine
   // safe-torque-off is never gated by the lock, so either pin drops power, except during a class 2 reaction in state 8
   wire sto_active = !safe_torque_off_a || !safe_torque_off_b;
   wire err_severe = err_in.valid && (err_in.eclass >= ECLASS_QSTOP_OFF) &&
      (err_in.eclass <= ECLASS_UNCTRL);
   wire err_class1 = err_in.valid && (err_in.eclass == ECLASS_QSTOP);
   wire err_warn = err_in.valid && (err_in.eclass == ECLASS_WARN);
   wire react_done = (eclass_reg != ECLASS_QSTOP_OFF) || standstill;
   wire stage_on = (state_reg == S_OP) || (state_reg == S_QSTOP);

   always_comb begin
      state_next = state_reg;
      eclass_next = eclass_reg;
      if (err_severe && state_reg != S_REACT && state_reg != S_FAULT) begin
         state_next = S_REACT;
         // with the stage already off a class 2 stop must not switch it back on
         eclass_next = (err_in.eclass == ECLASS_QSTOP_OFF && !stage_on) ? ECLASS_FATAL :
            err_in.eclass;
      end else begin
         unique case (state_reg)
            S_START: if (init_done) state_next = S_NOT_READY;
            S_NOT_READY: if (param_done) state_next = S_DISABLED;
            S_DISABLED: if (power_ok && !sto_active) state_next = S_READY;
            S_READY: begin
               if (!power_ok || sto_active) state_next = S_DISABLED;
               else if (cmd.enable_req) state_next = S_ON;
            end
            S_ON: begin
               if (cmd.disable_req || sto_active) state_next = S_DISABLED;
               else state_next = S_OP;
            end
            S_OP: begin
               if (cmd.disable_req || sto_active) state_next = S_DISABLED;
               else if (err_class1) state_next = S_QSTOP;
            end
            S_QSTOP: begin
               if (cmd.disable_req || sto_active) state_next = S_DISABLED;
               else if (cmd.fault_reset) state_next = S_OP;
            end
            S_REACT: if (react_done) state_next = S_FAULT;
            S_FAULT: begin
               // class 4 stays latched until power is removed
               if (cmd.fault_reset && !unclearable_reg) begin
                  state_next = S_DISABLED;
                  eclass_next = ECLASS_WARN;
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= S_START;
         eclass_reg <= ECLASS_WARN;
         unclearable_reg <= 1'b0;
      end else if (clk_en) begin
         state_reg <= state_next;
         eclass_reg <= eclass_next;
         if (err_in.valid && err_in.eclass == ECLASS_UNCTRL) begin
            unclearable_reg <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs
   logic [3:0] st_num;
   always_comb begin
      st_num = ST_NUM_START;
      for (int i = 0; i < 9; i++) begin
         if (state_reg[i]) st_num = 4'(i + 1);
      end
   end
   assign op_state = st_num;

   wire react_qstop = (state_reg == S_REACT) && (eclass_reg == ECLASS_QSTOP_OFF);
   assign power_enable = (state_reg == S_OP) || (state_reg == S_QSTOP) ||
      (react_qstop && !standstill);
   assign mode_run = (state_reg == S_OP);
   assign quick_stop = (state_reg == S_QSTOP) || react_qstop;
   assign warning = err_warn;
   assign motion_halt = halt_in;
   assign limit_pos_stop = pos_limit_switch;
   assign limit_neg_stop = neg_limit_switch;
   assign home_seen = home_switch;
   assign enable_refused = (state_reg == S_DISABLED) && cmd.enable_req;
   assign cmd_refused = fb_ref || tool_ref || io_ref || enable_refused;

   ////////////////////////////////////////////////////////////////////////
   // checks
   a_power_only_ok: assert property (@(posedge ref_clk) disable iff (!arst_n)
      mode_run |-> power_enable && op_state == 4'h6)
      else $error("mode running outside state 6");
   a_fault_power_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
      op_state == ST_NUM_FAULT |-> !power_enable)
      else $error("power stage on in fault");
   a_disable_goes3: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && (state_reg == S_OP || state_reg == S_QSTOP) && cmd.disable_req && !err_severe
      |=> op_state == 4'h3 && !power_enable)
      else $error("disable request not honoured");
   a_class1_qstop: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && state_reg == S_OP && err_class1 && !cmd.disable_req && !sto_active
      && !err_severe |=> quick_stop && power_enable)
      else $error("class 1 did not quick stop");
   a_severe_react: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && err_severe && state_reg != S_FAULT && state_reg != S_REACT
      |=> op_state == 4'h8)
      else $error("severe error not entering state 8");
   a_fatal_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
      state_reg == S_REACT && eclass_reg >= ECLASS_FATAL |-> !power_enable)
      else $error("fatal error kept power on");
   a_class4_sticky: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && state_reg == S_FAULT && unclearable_reg |=> state_reg == S_FAULT)
      else $error("class 4 fault cleared");
   a_enable_refused: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && state_reg == S_DISABLED |=> !power_enable)
      else $error("power enabled from state 3");
   a_off_stays_off: assert property (@(posedge ref_clk) disable iff (!arst_n)
      clk_en && err_severe && !stage_on && state_reg != S_REACT && state_reg != S_FAULT
      |=> !power_enable)
      else $error("error reaction switched power stage on");
   a_io_blocked: assert property (@(posedge ref_clk) disable iff (!arst_n)
      (lock_fieldbus || tool_exclusive) && io_cmd != '0 |-> cmd_refused)
      else $error("locked input not refused");
   a_halt_passes: assert property (@(posedge ref_clk) disable iff (!arst_n)
      lock_fieldbus && halt_in |-> motion_halt)
      else $error("hold lost under lock");

   c_reach_op: cover property (@(posedge ref_clk) state_reg == S_OP);
   c_qstop_back: cover property (@(posedge ref_clk) state_reg == S_QSTOP ##1 state_reg == S_OP);
   c_fault_reset: cover property (@(posedge ref_clk) state_reg == S_FAULT ##1 state_reg == S_DISABLED);
   c_lock_refuse: cover property (@(posedge ref_clk) lock_fieldbus && io_ref);
endmodule

// file: test/dsac_fb_master.sv
`timescale 1ns/1ps
// fieldbus master stand-in: parameter port and control words
module dsac_fb_master
   import dsac_pkg::*;
(
   input wire logic ref_clk,
   output logic par_wr,
   output logic par_rd,
   output logic [11:0] par_addr,
   output logic [15:0] par_wdata,
   input wire logic [15:0] par_rdata,
   output dsac_pkg::dsac_cmd_t fb_cmd
);
   import dsac_pkg::*;
   initial begin
      par_wr = 1'b0;
      par_rd = 1'b0;
      par_addr = 12'h000;
      par_wdata = 16'h0000;
      fb_cmd = '0;
   end
   ////////////////////////////////////////////////////////////////
   // released lines show the inverse so a stale value never looks valid
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      par_addr = a;
      par_wdata = d;
      par_wr = 1'b1;
      @(negedge ref_clk);
      par_wr = 1'b0;
      par_addr = ~a;
      par_wdata = ~d;
      // one idle edge so a following request never retimes these lines
      @(negedge ref_clk);
   endtask
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      par_addr = a;
      par_rd = 1'b1;
      @(negedge ref_clk);
      d = par_rdata;
      par_rd = 1'b0;
      par_addr = ~a;
      @(negedge ref_clk);
   endtask
   // source of the fieldbus control word fb_cmd only; tool_cmd, io_cmd and mode_sel are driven by the top
   task automatic cmd(input dsac_cmd_t c);
      fb_cmd = c;
   endtask
endmodule

// file: test/drive_state_access_control_tb_top.sv
`timescale 1ns/1ps
module drive_state_access_control_tb_top;
   import dsac_pkg::*;
   localparam dsac_cmd_t EN = 3'h4;
   localparam dsac_cmd_t DIS = 3'h2;
   localparam dsac_cmd_t FR = 3'h1;
   logic ref_clk, arst_n, par_wr, par_rd, tool_exclusive, halt_in;
   logic pos_limit_switch, neg_limit_switch, home_switch, safe_torque_off_a;
   logic safe_torque_off_b, init_done, param_done, power_ok, standstill;
   logic power_enable, quick_stop, motion_halt, limit_pos_stop, limit_neg_stop;
   logic home_seen, mode_run, warning, cmd_refused, smp, clk_en;
   logic [11:0] par_addr;
   logic [15:0] par_wdata, par_rdata, rdv;
   logic [2:0] mode_sel;
   logic [3:0] op_state;
   dsac_cmd_t fb_cmd, tool_cmd, io_cmd;
   dsac_err_t err_in;
   dsac_loop_t loop_sel;
   int error_cnt = 0;
   int n_tests = 0;
   dsac_supervisor dsac_supervisor_inst (.ref_clk, .arst_n, .clk_en, .par_wr,
      .par_rd, .par_addr, .par_wdata, .par_rdata, .fb_cmd, .tool_cmd, .io_cmd,
      .tool_exclusive, .halt_in, .pos_limit_switch, .neg_limit_switch, .home_switch,
      .safe_torque_off_a, .safe_torque_off_b, .init_done, .param_done, .power_ok,
      .err_in, .standstill, .mode_sel, .power_enable, .quick_stop, .motion_halt,
      .limit_pos_stop, .limit_neg_stop, .home_seen, .mode_run, .warning, .loop_sel,
      .op_state, .cmd_refused);
   dsac_fb_master dsac_fb_master_inst (.ref_clk, .par_wr, .par_rd, .par_addr,
      .par_wdata, .par_rdata, .fb_cmd);
   ////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic results;
      if (error_cnt == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   // refusal is combinational, so it is caught mid-cycle while the word stands
   task automatic issue(input int ch, input dsac_cmd_t c);
      if (ch == 0) dsac_fb_master_inst.cmd(c);
      else if (ch == 1) tool_cmd = c;
      else io_cmd = c;
      #5 smp = cmd_refused;
      cyc(1);
      if (ch == 0) dsac_fb_master_inst.cmd('0);
      else if (ch == 1) tool_cmd = '0;
      else io_cmd = '0;
   endtask
   task automatic err(input logic [2:0] cls);
      err_in = {1'b1, cls};
      #5 smp = warning;
      cyc(1);
      err_in = '0;
   endtask
   task automatic go6;
      power_ok = 1'b1;
      cyc(2);
      issue(0, EN);
      cyc(1);
      chk({power_enable, mode_run, op_state}, 6'h36);
   endtask
   ////////////////////////////////////////////////////////////////
   task automatic t_bringup;
      chk({power_enable, op_state}, {1'b0, ST_NUM_START});
      dsac_fb_master_inst.rd(CHANNEL_LOCK_OFFSET, rdv);
      chk(rdv, CHANNEL_LOCK_RESET);
      init_done = 1'b1;
      cyc(1);
      chk(op_state, 4'h2);
      param_done = 1'b1;
      cyc(1);
      issue(0, EN);
      chk({smp, op_state}, 5'h13);
      go6;
      dsac_fb_master_inst.rd(OP_STATE_OFFSET, rdv);
      chk(rdv, 16'h0006);
   endtask
   task automatic t_modes;
      for (int m = 1; m <= 5; m++) begin
         mode_sel = m[2:0];
         cyc(2);
         chk(loop_sel, (m == 2) ? 3'b010 : 3'b101);
      end
   endtask
   task automatic t_lock;
      dsac_fb_master_inst.wr(CHANNEL_LOCK_OFFSET, LOCK_FIELDBUS_VAL);
      dsac_fb_master_inst.rd(CHANNEL_LOCK_OFFSET, rdv);
      chk(rdv, LOCK_FIELDBUS_VAL);
      dsac_fb_master_inst.rd(12'h000, rdv);
      chk(rdv, 16'h0000);
      issue(1, DIS);
      chk({smp, op_state}, 5'h16);
      issue(2, DIS);
      chk({smp, op_state}, 5'h16);
      {halt_in, pos_limit_switch, neg_limit_switch, home_switch} = 4'hf;
      cyc(1);
      chk({motion_halt, limit_pos_stop, limit_neg_stop, home_seen}, 4'hf);
      {halt_in, pos_limit_switch, neg_limit_switch, home_switch} = 4'h0;
      dsac_fb_master_inst.wr(CHANNEL_LOCK_OFFSET, LOCK_RELEASE_VAL);
      issue(1, DIS);
      chk({smp, op_state}, 5'h03);
      go6;
   endtask
   task automatic t_tool;
      tool_exclusive = 1'b1;
      issue(0, DIS);
      chk({smp, op_state}, 5'h16);
      issue(2, DIS);
      chk({smp, op_state}, 5'h16);
      tool_exclusive = 1'b0;
      cyc(1);
      issue(2, DIS);
      chk({smp, op_state}, 5'h03);
      go6;
   endtask
   task automatic t_freeze;
      clk_en = 1'b0;
      issue(0, DIS);
      chk({power_enable, op_state}, 5'h16);
      clk_en = 1'b1;
   endtask
   task automatic t_errors;
      err(ECLASS_WARN);
      chk({smp, op_state}, 5'h16);
      cyc(1);
      err(ECLASS_QSTOP);
      chk({quick_stop, power_enable, op_state}, 6'h37);
      issue(0, FR);
      chk(op_state, 4'h6);
      err(ECLASS_QSTOP);
      issue(0, DIS);
      chk({power_enable, op_state}, 5'h03);
      go6;
      safe_torque_off_a = 1'b0;
      cyc(1);
      chk({power_enable, op_state}, 5'h03);
      safe_torque_off_a = 1'b1;
      go6;
      err(ECLASS_QSTOP_OFF);
      cyc(1);
      chk({quick_stop, power_enable, op_state}, 6'h38);
      standstill = 1'b1;
      cyc(2);
      chk({power_enable, op_state}, 5'h09);
      standstill = 1'b0;
      issue(0, FR);
      chk(op_state, 4'h3);
      go6;
      err(ECLASS_FATAL);
      chk({quick_stop, power_enable, op_state}, 6'h08);
      cyc(1);
      chk(op_state, 4'h9);
      issue(0, FR);
      go6;
      err(ECLASS_UNCTRL);
      cyc(1);
      chk({power_enable, op_state}, 5'h09);
      issue(0, FR);
      chk(op_state, 4'h9);
      // only a power cycle, modelled by reset, drops the class 4 latch
      arst_n = 1'b0;
      cyc(1);
      arst_n = 1'b1;
      chk({power_enable, op_state}, 5'h01);
      cyc(3);
      chk(op_state, 4'h4);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      arst_n = 1'b0;
      clk_en = 1'b1;
      {tool_cmd, io_cmd, tool_exclusive, init_done, param_done, power_ok} = '0;
      {halt_in, pos_limit_switch, neg_limit_switch, home_switch} = 4'h0;
      {safe_torque_off_a, safe_torque_off_b} = 2'b11;
      err_in = '0;
      standstill = 1'b0;
      mode_sel = MODE_JOG;
      cyc(5);
      arst_n = 1'b1;
      t_bringup;
      t_modes;
      t_lock;
      t_tool;
      t_freeze;
      t_errors;
      results;
   end
   // the full sequence needs about 90 cycles; allow about 4000
   initial begin
      #100000;
      error_cnt++;
      results;
   end
endmodule
